// ---- ddc_cmd_decode.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ddc_cmd_decode
   import ddc_pkg::*;
#(
   parameter logic [DDC_CNT_W-1:0] WL    = DDC_WL_DEF,     // Write latency
   parameter logic [DDC_CNT_W-1:0] XPDLL = DDC_XPDLL_DEF,  // DLL relock exit delay
   parameter logic [DDC_CNT_W-1:0] CPDED = DDC_CPDED_DEF   // Entry command delay
) (
   input  wire logic                  clock_in,       // Device clock
   input  wire logic                  rst_in,         // Synchronous reset
   input  wire logic                  cke_in,         // Clock enable
   input  wire logic                  cs_n_in,        // Chip select, low active
   input  wire logic                  ras_n_in,       // Row strobe, low active
   input  wire logic                  cas_n_in,       // Column strobe, low active
   input  wire logic                  we_n_in,        // Write enable, low active
   input  wire logic [DDC_BANK_W-1:0] bank_in,        // Bank address
   input  wire logic [DDC_ADDR_W-1:0] addr_in,        // Address bus
   input  wire logic                  otf_en_in,      // On-the-fly burst enabled
   input  wire logic                  mr_bc4_in,      // Fixed burst is chop four
   input  wire logic                  pd_dll_fast_in, // DLL kept on in precharge PD
   input  wire logic                  lead_cke_in,    // CKE level WL-1 clocks ahead
   output ddc_cmd_t                   cmd_out,        // Decoded command
   output logic                       cmd_vld_out,    // Command strobe
   output logic [DDC_BANK_W-1:0]      bank_out,       // Bank of command
   output logic [DDC_COL_W-1:0]       col_out,        // Column of read or write
   output logic [DDC_ADDR_W-1:0]      op_out,         // Row, mode code or raw address
   output logic                       bc4_out,        // Burst chopped to four
   output logic                       ap_out,         // Auto precharge or all banks
   output logic                       burst_out,      // Burst in progress
   output logic                       odt_async_out,  // Termination timing uncertain
   output logic                       pd_out          // In power-down or self refresh
);

   ////////////////////////////////////////////////////////////////////////////
   // Command classification

   logic     cke_prev_r;
   logic     cke_prev_nxt;
   ddc_cmd_t cmd_c;
   logic     bc4_c;
   logic     pd_r;           // In precharge or active power-down
   logic     pd_nxt;
   logic     sr_r;           // In self refresh
   logic     sr_nxt;

   // Combinational decode of the pins at this edge
   always_comb begin
      cmd_c = DDC_CMD_ILLEGAL;
      if (cke_prev_r && cke_in) begin
         if (cs_n_in) begin
            cmd_c = DDC_CMD_DES;
         end else begin
            unique case ({ras_n_in, cas_n_in, we_n_in})
               3'b000: cmd_c = DDC_CMD_MRS;
               3'b001: cmd_c = DDC_CMD_REF;
               3'b010: cmd_c = addr_in[DDC_AP_BIT] ? DDC_CMD_PREA : DDC_CMD_PRE;
               3'b011: cmd_c = DDC_CMD_ACT;
               3'b100: cmd_c = addr_in[DDC_AP_BIT] ? DDC_CMD_WRA : DDC_CMD_WR;
               3'b101: cmd_c = addr_in[DDC_AP_BIT] ? DDC_CMD_RDA : DDC_CMD_RD;
               3'b110: cmd_c = addr_in[DDC_AP_BIT] ? DDC_CMD_ZQCL : DDC_CMD_ZQCS;
               3'b111: cmd_c = DDC_CMD_NOP;
            endcase
         end
      end else if (cke_prev_r && !cke_in) begin
         if (!cs_n_in && {ras_n_in, cas_n_in, we_n_in} == 3'b001) begin
            cmd_c = DDC_CMD_SRE;
         end else if (cs_n_in || {ras_n_in, cas_n_in, we_n_in} == 3'b111) begin
            cmd_c = DDC_CMD_PDE;
         end
      end else if (!cke_prev_r && cke_in) begin
         if (cs_n_in || {ras_n_in, cas_n_in, we_n_in} == 3'b111) begin
            cmd_c = pd_r ? DDC_CMD_PDX : DDC_CMD_SRX;
         end
      end else begin
         cmd_c = DDC_CMD_NONE; // CKE held low: pins ignored
      end
   end

   // Burst length selection, fixed or per command
   always_comb begin
      if (otf_en_in) begin
         bc4_c = !addr_in[DDC_BC_BIT];
      end else begin
         bc4_c = mr_bc4_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered command outputs

   ddc_cmd_t                  cmd_r,   cmd_nxt;
   logic                      vld_r,   vld_nxt;
   logic [DDC_BANK_W-1:0]     bank_r,  bank_nxt;
   logic [DDC_COL_W-1:0]      col_r,   col_nxt;
   logic [DDC_ADDR_W-1:0]     op_r,    op_nxt;
   logic                      bc4_r,   bc4_nxt;
   logic                      ap_r,    ap_nxt;

   // Capture fields of the decoded command
   always_comb begin
      cke_prev_nxt = cke_in;
      cmd_nxt      = cmd_c;
      vld_nxt      = (cmd_c != DDC_CMD_NONE) && (cmd_c != DDC_CMD_DES) && (cmd_c != DDC_CMD_NOP);
      bank_nxt     = bank_r;
      col_nxt      = col_r;
      op_nxt       = op_r;
      bc4_nxt      = bc4_r;
      ap_nxt       = addr_in[DDC_AP_BIT];
      unique case (cmd_c)
         DDC_CMD_WR, DDC_CMD_WRA, DDC_CMD_RD, DDC_CMD_RDA: begin
            bank_nxt = bank_in;
            col_nxt  = {addr_in[DDC_COL_HI_BIT], addr_in[9:0]};
            bc4_nxt  = bc4_c;
         end
         DDC_CMD_MRS, DDC_CMD_ACT, DDC_CMD_PRE, DDC_CMD_PREA: begin
            bank_nxt = bank_in;
            op_nxt   = addr_in;
         end
         default: begin
            ap_nxt = ap_r;
         end
      endcase
   end

   // Command and field registers; previous CKE resets low so the first high edge reads as an exit
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cke_prev_r <= 1'b0;
         cmd_r      <= DDC_CMD_NONE;
         vld_r      <= 1'b0;
         bank_r     <= '0;
         col_r      <= '0;
         op_r       <= '0;
         bc4_r      <= 1'b0;
         ap_r       <= 1'b0;
      end else begin
         cke_prev_r <= cke_prev_nxt;
         cmd_r      <= cmd_nxt;
         vld_r      <= vld_nxt;
         bank_r     <= bank_nxt;
         col_r      <= col_nxt;
         op_r       <= op_nxt;
         bc4_r      <= bc4_nxt;
         ap_r       <= ap_nxt;
      end
   end

   assign cmd_out     = cmd_r;
   assign cmd_vld_out = vld_r;
   assign bank_out    = bank_r;
   assign col_out     = col_r;
   assign op_out      = op_r;
   assign bc4_out     = bc4_r;
   assign ap_out      = ap_r;

   ////////////////////////////////////////////////////////////////////////////
   // Burst tracking: only a new read or write restarts the count

   logic [2:0] beat_r;
   logic [2:0] beat_nxt;
   logic       is_rw_c;

   // A new read or write reloads the beat count; NOP and deselect only count down
   always_comb begin
      is_rw_c  = (cmd_c == DDC_CMD_WR) || (cmd_c == DDC_CMD_WRA) ||
                 (cmd_c == DDC_CMD_RD) || (cmd_c == DDC_CMD_RDA);
      beat_nxt = beat_r;
      if (is_rw_c) begin
         beat_nxt = bc4_c ? 3'h2 : 3'h4;
      end else if (beat_r != 3'h0) begin
         beat_nxt = beat_r - 3'h1;
      end
   end

   // Beat counter register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         beat_r <= 3'h0;
      end else begin
         beat_r <= beat_nxt;
      end
   end

   assign burst_out = (beat_r != 3'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Power-down state

   // Power-down and self refresh flags, both cleared by any CKE rise
   always_comb begin
      pd_nxt = pd_r;
      sr_nxt = sr_r;
      if (cmd_c == DDC_CMD_PDE) begin
         pd_nxt = 1'b1;
      end else if (cmd_c == DDC_CMD_SRE) begin
         sr_nxt = 1'b1;
      end else if (!cke_prev_r && cke_in) begin
         pd_nxt = 1'b0;
         sr_nxt = 1'b0;
      end
   end

   // Power state registers
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pd_r <= 1'b0;
         sr_r <= 1'b0;
      end else begin
         pd_r <= pd_nxt;
         sr_r <= sr_nxt;
      end
   end

   assign pd_out = pd_r || sr_r;

   ////////////////////////////////////////////////////////////////////////////
   // Uncertain termination windows around power-down entry and exit

   logic frz_c;
   logic lead_rise_c;
   logic lead_fall_c;
   logic lead_prev_r;
   logic lead_prev_nxt;
   logic lead_open_r;
   logic lead_open_nxt;
   logic exit_open_c;
   logic entry_open_c;

   // Window only exists when the DLL freezes in precharge power-down
   assign frz_c = !pd_dll_fast_in;

   // The lead CKE copy runs WL-1 clocks ahead, so its edges mark window starts
   always_comb begin
      lead_prev_nxt = lead_cke_in;
      lead_rise_c   = frz_c && lead_cke_in && !lead_prev_r;
      lead_fall_c   = frz_c && !lead_cke_in && lead_prev_r;
      lead_open_nxt = lead_open_r;
      if (lead_rise_c || lead_fall_c) begin
         lead_open_nxt = 1'b1;
      end else if (cke_in != cke_prev_r) begin
         lead_open_nxt = 1'b0;
      end
   end

   // Lead copy resets to its idle high level so that reset makes no false edge
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         lead_prev_r <= 1'b1;
         lead_open_r <= 1'b0;
      end else begin
         lead_prev_r <= lead_prev_nxt;
         lead_open_r <= lead_open_nxt;
      end
   end

   // Tail after first CKE high, closing after the DLL relock delay
   ddc_win_cnt #(
      .W (DDC_CNT_W)
   ) u_exit_win (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .load_in  (frz_c && !cke_prev_r && cke_in),
      .len_in   (XPDLL),
      .open_out (exit_open_c)
   );

   // Tail after first CKE low, closing after the entry command delay
   ddc_win_cnt #(
      .W (DDC_CNT_W)
   ) u_entry_win (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .load_in  (frz_c && cke_prev_r && !cke_in),
      .len_in   (CPDED),
      .open_out (entry_open_c)
   );

   // Overlapping windows merge because each piece stays open until its own end
   assign odt_async_out = lead_open_r || exit_open_c || entry_open_c;

endmodule

// ---- ddc_cmd_decode_bench.sv ----
`timescale 1ns/1ps

// Self-checking bench for the command decoder
module ddc_cmd_decode_bench
   import ddc_pkg::*;
;
   localparam logic [7:0] WL_B = 8'h05;
   localparam logic [7:0] XP_B = 8'h0A;
   localparam logic [3:0] P_NOP = 4'h7;
   localparam logic [3:0] P_DES = 4'hF;
   logic        clock_in = 1'b0;
   logic        rst_in, cke, otf_en, mr_bc4, pd_fast, lead;
   logic [3:0]  pins;
   logic [2:0]  bank, bank_o;
   logic [14:0] addr;
   logic [10:0] col_o;
   logic [14:0] op_o;
   logic        vld, bc4, ap, burst, odt, pd;
   ddc_cmd_t    cmd;
   int          n_fail = 0;
   int          tests_run = 0;
   always #5 clock_in = ~clock_in;
   ddc_ctl_model ctl_i (.cke_out(cke), .pins_out(pins), .bank_out(bank), .addr_out(addr), .lead_out(lead));
   ddc_cmd_decode #(.WL(WL_B), .XPDLL(XP_B), .CPDED(8'h01)) ddc_cmd_decode_i (.clock_in(clock_in),
      .rst_in(rst_in), .cke_in(cke), .cs_n_in(pins[3]), .ras_n_in(pins[2]), .cas_n_in(pins[1]),
      .we_n_in(pins[0]), .bank_in(bank), .addr_in(addr), .otf_en_in(otf_en), .mr_bc4_in(mr_bc4),
      .pd_dll_fast_in(pd_fast), .lead_cke_in(lead), .cmd_out(cmd), .cmd_vld_out(vld), .bank_out(bank_o),
      .col_out(col_o), .op_out(op_o), .bc4_out(bc4), .ap_out(ap), .burst_out(burst), .odt_async_out(odt),
      .pd_out(pd));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick;
      @(posedge clock_in);
      #1;
   endtask
   task automatic check(input logic [14:0] seen, input logic [14:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task automatic nop(input logic k);
      ctl_i.drive(k, P_NOP, 3'h0, 15'h0000);
   endtask
   // Every read and write form, then its burst counted under NOPs
   task automatic t_rw;
      logic [14:0] a;
      logic        bc;
      int          n;
      for (int i = 0; i < 8; i++) begin
         otf_en = i[2];
         mr_bc4 = i[0];
         a = {2'h3, i[0] ^ i[1], 1'b1, i[1], 10'h2A5 ^ 10'(i)};
         bc = i[2] ? !a[12] : i[0];
         ctl_i.drive(1'b1, {3'b010, i[0]}, 3'(i), a);
         tick;
         nop(1'b1);
         check(cmd, i[0] ? (i[1] ? DDC_CMD_RDA : DDC_CMD_RD) : (i[1] ? DDC_CMD_WRA : DDC_CMD_WR), "rw");
         check(bc4, bc, "chop");
         check(ap, i[1], "auto precharge");
         check({bank_o, col_o}, {3'(i), 1'b1, a[9:0]}, "bank column");
         n = 0;
         while (burst === 1'b1 && n < 20) begin
            n++;
            tick;
         end
         check(15'(n), bc ? 15'h0002 : 15'h0004, "burst length");
      end
      $display("t_rw finished");
   endtask
   // Deselect in mid-burst acts as NOP
   task automatic t_des;
      otf_en = 1'b0;
      mr_bc4 = 1'b0;
      ctl_i.drive(1'b1, 4'h4, 3'h1, 15'h0010);
      tick;
      ctl_i.drive(1'b1, P_DES, 3'h0, 15'h0000);
      tick;
      check({vld, burst}, 2'b01, "deselect");
      nop(1'b1);
      repeat (6) tick;
      $display("t_des finished");
   endtask
   // Remaining commands from a table
   task automatic t_cmds;
      logic [3:0]  p [7] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h6, 4'h6};
      ddc_cmd_t    e [7] = '{DDC_CMD_MRS, DDC_CMD_REF, DDC_CMD_PRE, DDC_CMD_PREA, DDC_CMD_ACT, DDC_CMD_ZQCL,
                             DDC_CMD_ZQCS};
      logic [6:0]  apb = 7'b0101000;
      logic [14:0] a;
      for (int i = 0; i < 7; i++) begin
         a = {4'h5, apb[i], 10'h0C3 ^ 10'(i)};
         ctl_i.drive(1'b1, p[i], 3'h2, a);
         tick;
         nop(1'b1);
         check(cmd, e[i], "command");
         check(vld, 1'b1, "strobe");
         if (p[i] != 4'h1 && p[i] != 4'h6) check(op_o, a, "operand");
         tick;
      end
      $display("t_cmds finished");
   endtask
   // Power-down entry and exit with its termination window
   task automatic t_pd(input logic fast);
      pd_fast = fast;
      ctl_i.lead(1'b0);
      repeat (WL_B - 1) tick;
      nop(1'b0);
      tick;
      check(cmd, DDC_CMD_PDE, "entry");
      repeat (3) tick;
      check({cmd, pd}, {DDC_CMD_NONE, 1'b1}, "held low");
      ctl_i.lead(1'b1);
      tick;
      check(odt, !fast, "window start");
      repeat (WL_B - 2) tick;
      nop(1'b1);
      tick;
      check(cmd, DDC_CMD_PDX, "exit");
      repeat (XP_B - 2) tick;
      check(odt, !fast, "window tail");
      repeat (4) tick;
      check(odt, 1'b0, "window end");
      $display("t_pd finished");
   endtask
   // Self refresh entry and exit
   task automatic t_sr;
      ctl_i.drive(1'b0, 4'h1, 3'h0, 15'h0000);
      tick;
      nop(1'b0);
      check(cmd, DDC_CMD_SRE, "self refresh entry");
      repeat (3) tick;
      nop(1'b1);
      tick;
      check(cmd, DDC_CMD_SRX, "self refresh exit");
      $display("t_sr finished");
   endtask
   // Short power-down and short idle: entry and exit windows overlap and merge
   task automatic t_short;
      pd_fast = 1'b0;
      ctl_i.lead(1'b0);
      repeat (WL_B - 1) tick;
      nop(1'b0);
      ctl_i.lead(1'b1);
      repeat (WL_B - 1) begin
         tick;
         check(odt, 1'b1, "short power-down");
      end
      nop(1'b1);
      tick;
      check({cmd, odt}, {DDC_CMD_PDX, 1'b1}, "short exit");
      ctl_i.lead(1'b0);
      repeat (WL_B - 1) begin
         tick;
         check(odt, 1'b1, "short idle");
      end
      nop(1'b0);
      tick;
      check({cmd, odt}, {DDC_CMD_PDE, 1'b1}, "short entry");
      ctl_i.lead(1'b1);
      repeat (WL_B - 1) tick;
      nop(1'b1);
      tick;
      check(cmd, DDC_CMD_PDX, "leave power-down");
      $display("t_short finished");
   endtask
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_in = 1'b1;
      otf_en = 1'b0;
      mr_bc4 = 1'b0;
      pd_fast = 1'b0;
      repeat (2) tick;
      rst_in = 1'b0;
      nop(1'b1);
      repeat (3) tick;
      t_rw;
      t_des;
      t_cmds;
      t_pd(1'b0);
      t_pd(1'b1);
      t_short;
      t_sr;
      complete_run;
   end
   // Watchdog
   initial begin
      #50000;
      n_fail++;
      complete_run;
   end
endmodule

// ---- ddc_cmd_decode_props.sv ----
`timescale 1ns/1ps

// Port checker for the command decoder
module ddc_cmd_decode_props
   import ddc_pkg::*;
(
   input wire logic                  clock_in,       // Clock
   input wire logic                  rst_in,         // Reset
   input wire logic                  cke_in,         // Clock enable
   input wire logic                  cs_n_in,        // Chip select
   input wire logic                  ras_n_in,       // Row strobe
   input wire logic                  cas_n_in,       // Column strobe
   input wire logic                  we_n_in,        // Write enable
   input wire logic [DDC_BANK_W-1:0] bank_in,        // Bank address
   input wire logic [DDC_ADDR_W-1:0] addr_in,        // Address
   input wire logic                  otf_en_in,      // On-the-fly chop
   input wire logic                  mr_bc4_in,      // Fixed chop four
   input wire logic                  pd_dll_fast_in, // DLL kept on
   input wire logic                  lead_cke_in,    // Early CKE intent
   input wire ddc_cmd_t              cmd_out,        // Decoded command
   input wire logic                  cmd_vld_out,    // Command strobe
   input wire logic [DDC_BANK_W-1:0] bank_out,       // Bank field
   input wire logic [DDC_COL_W-1:0]  col_out,        // Column field
   input wire logic                  bc4_out,        // Chop four
   input wire logic                  burst_out,      // Burst running
   input wire logic                  odt_async_out,  // Uncertain window
   input wire logic                  pd_out          // Power-down
);
   logic cke_q_r; // Previous CKE sample
   logic col_c;   // Read or write pins
   logic nop_c;   // NOP or deselect pins
   // Previous CKE, low out of reset like the decoder's own
   always_ff @(posedge clock_in) begin
      cke_q_r <= rst_in ? 1'b0 : cke_in;
   end
   // Pin classes
   assign col_c = cke_q_r & cke_in & !cs_n_in & ras_n_in & !cas_n_in;
   assign nop_c = cke_q_r & cke_in & (cs_n_in | (ras_n_in & cas_n_in & we_n_in));
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////////////////////
   wr_decode_a: assert property (col_c && !we_n_in |=>
      cmd_out == ($past(addr_in[DDC_AP_BIT]) ? DDC_CMD_WRA : DDC_CMD_WR)) else $error("write decode");
   rd_decode_a: assert property (col_c && we_n_in |=>
      cmd_out == ($past(addr_in[DDC_AP_BIT]) ? DDC_CMD_RDA : DDC_CMD_RD)) else $error("read decode");
   otf_chop_a: assert property (col_c && otf_en_in |=> bc4_out == !$past(addr_in[DDC_BC_BIT]))
      else $error("on-the-fly chop");
   fixed_len_a: assert property (col_c && !otf_en_in |=> bc4_out == $past(mr_bc4_in))
      else $error("fixed burst length");
   col_field_a: assert property (col_c |=> bank_out == $past(bank_in) &&
      col_out == {$past(addr_in[11]), $past(addr_in[9:0])}) else $error("bank or column field");
   nop_quiet_a: assert property (nop_c |=> !cmd_vld_out) else $error("NOP gave a strobe");
   burst_run_a: assert property (col_c && !otf_en_in && !mr_bc4_in |=> burst_out [*4])
      else $error("burst cut short");
   cke_off_a: assert property (!cke_q_r && !cke_in |=> cmd_out == DDC_CMD_NONE)
      else $error("command while CKE low");
   lead_open_a: assert property ($rose(lead_cke_in) && pd_out && !pd_dll_fast_in |-> ##[0:1] odt_async_out)
      else $error("exit window late");
   exit_tail_a: assert property ($rose(cke_in) && pd_out && !pd_dll_fast_in |=> odt_async_out [*8])
      else $error("exit window short");
endmodule

bind ddc_cmd_decode ddc_cmd_decode_props ddc_cmd_decode_props_i (.clock_in(clock_in), .rst_in(rst_in),
   .cke_in(cke_in), .cs_n_in(cs_n_in), .ras_n_in(ras_n_in), .cas_n_in(cas_n_in), .we_n_in(we_n_in),
   .bank_in(bank_in), .addr_in(addr_in), .otf_en_in(otf_en_in), .mr_bc4_in(mr_bc4_in),
   .pd_dll_fast_in(pd_dll_fast_in), .lead_cke_in(lead_cke_in), .cmd_out(cmd_out), .cmd_vld_out(cmd_vld_out),
   .bank_out(bank_out), .col_out(col_out), .bc4_out(bc4_out), .burst_out(burst_out),
   .odt_async_out(odt_async_out), .pd_out(pd_out));

// ---- ddc_ctl_model.sv ----
`timescale 1ns/1ps

// Controller side of the command bus
module ddc_ctl_model
   import ddc_pkg::*;
(
   output logic                  cke_out,   // Clock enable
   output logic [3:0]            pins_out,  // CS, RAS, CAS, WE
   output logic [DDC_BANK_W-1:0] bank_out,  // Bank address
   output logic [DDC_ADDR_W-1:0] addr_out,  // Address
   output logic                  lead_out   // CKE intent ahead
);
   // Deselected with CKE low through reset
   initial begin
      cke_out = 1'b0;
      pins_out = 4'hF;
      bank_out = 3'h0;
      addr_out = 15'h0000;
      lead_out = 1'b1;
   end
   // One command per edge, called just after an edge
   task automatic drive(input logic k, input logic [3:0] p, input logic [2:0] b, input logic [14:0] a);
      cke_out = k;
      pins_out = p;
      bank_out = p[3] ? ~bank_out : b; // Lines of a deselected device do not hold
      addr_out = p[3] ? ~addr_out : a;
   endtask
   // Early CKE intent; while the decoder flags the window, either termination timing is accepted
   task automatic lead(input logic v);
      lead_out = v;
   endtask
endmodule

// ---- ddc_pkg.sv ----
package ddc_pkg;

   // Decoded command classes
   typedef enum logic [4:0] {
      DDC_CMD_NONE,
      DDC_CMD_MRS,
      DDC_CMD_REF,
      DDC_CMD_SRE,
      DDC_CMD_SRX,
      DDC_CMD_PRE,
      DDC_CMD_PREA,
      DDC_CMD_ACT,
      DDC_CMD_WR,
      DDC_CMD_WRA,
      DDC_CMD_RD,
      DDC_CMD_RDA,
      DDC_CMD_NOP,
      DDC_CMD_DES,
      DDC_CMD_PDE,
      DDC_CMD_PDX,
      DDC_CMD_ZQCL,
      DDC_CMD_ZQCS,
      DDC_CMD_ILLEGAL
   } ddc_cmd_t;

   // Address field positions
   localparam int DDC_AP_BIT     = 10;
   localparam int DDC_BC_BIT     = 12;
   localparam int DDC_COL_HI_BIT = 11;

   // Widths
   localparam int DDC_ADDR_W = 15;
   localparam int DDC_BANK_W = 3;
   localparam int DDC_COL_W  = 11;
   localparam int DDC_CNT_W  = 8;

   // Timing defaults, in clocks
   localparam logic [DDC_CNT_W-1:0] DDC_WL_DEF     = 8'h05;
   localparam logic [DDC_CNT_W-1:0] DDC_XPDLL_DEF  = 8'h0A;
   localparam logic [DDC_CNT_W-1:0] DDC_CPDED_DEF  = 8'h01;

   // Reset values
   localparam logic [DDC_CNT_W-1:0] DDC_CNT_RST = 8'h00;

endpackage

// ---- ddc_win_cnt.sv ----
`timescale 1ns/1ps

// Down counter that holds a window open for a loaded number of clocks
module ddc_win_cnt
   import ddc_pkg::*;
#(
   parameter int W = DDC_CNT_W
) (
   input  wire logic         clock_in,  // Clock
   input  wire logic         rst_in,    // Synchronous reset
   input  wire logic         load_in,   // Start or restart window
   input  wire logic [W-1:0] len_in,    // Clocks after the load edge
   output logic              open_out   // Window open
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // Next count
   always_comb begin
      cnt_nxt = cnt_r;
      if (load_in) begin
         cnt_nxt = len_in;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - W'(1);
      end
   end

   // Count register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign open_out = load_in || (cnt_r != '0);

endmodule
